/* File: core/fac_map.vh */
`ifndef FAC_MAP_VH
`define FAC_MAP_VH
// Erase and program maxima in microseconds, and the system clock in MHz.
`define FAC_T_ER_US          8000
`define FAC_T_PR_US          3500
`define FAC_CLK_MHZ          100
// Busy counts derived from the maxima; a longest time rounds down.
`define FAC_ER_CYC           (`FAC_T_ER_US * `FAC_CLK_MHZ)
`define FAC_PR_CYC           (`FAC_T_PR_US * `FAC_CLK_MHZ)
// Number of modules and the module that may be written while it is the read source.
`define FAC_NUM_MOD          5
`define FAC_FREE_MOD         3'h4
`define FAC_SCRATCH_SRC      3'h7
// Reset values of the wait state controls.
`define FAC_WS_RST           3'h4
`define FAC_WSE_RST          1'h0
// Operation codes.
`define FAC_OP_ERASE         1'h0
`define FAC_OP_PROG          1'h1
// Control sequencer overhead in system cycles.
`define FAC_SM_OVH           2'h2
`endif

/* File: core/fac_flash_ctrl.v */
// Overview of operation
// - Erase or program allowed on any module but the read source while reads stay in one source.
// - Module 4 accepts erase and program whatever module is being read, except while module 4 is busy or with multi-source reads while any module is busy.
// - Page program ends within 3.5 ms, sector erase within 8.0 ms.
// - Durations come from the flash time base plus a few system cycles.
// - Wait states apply to non-sequential reads only; sequential use prefetch.
// - A prefetch buffer fetches ahead along sequential addresses.
// - Cache hit has no wait state; a miss adds one more unless the wait count and extension are both zero.
`timescale 1ns/10ps
`include "fac_map.vh"
module fac_flash_ctrl #(
    parameter ADDR_W  = 16,
    parameter ER_CYC  = `FAC_ER_CYC,
    parameter PR_CYC  = `FAC_PR_CYC,
    parameter TB_DIV  = 100
) (
    input  wire              CLK_SYS,
    input  wire              SRST,
    input  wire [2:0]        WAIT_STATE_COUNT,
    input  wire              WAIT_STATE_EXTENSION,
    input  wire              SAFE_ACCESS_AFTER_RESET,
    input  wire              RD_REQ,
    input  wire [ADDR_W-1:0] RD_ADDR,
    input  wire              RD_CACHEABLE,
    input  wire [2:0]        RD_SRC,
    input  wire              RD_MULTI_SRC,
    input  wire              OP_REQ,
    input  wire              OP_KIND,
    input  wire [2:0]        OP_MODULE,
    output reg               RD_DONE,
    output reg               RD_SEQ_HIT,
    output reg               RD_CACHE_HIT,
    output reg               OP_ACCEPT,
    output reg               OP_REJECT,
    output reg  [4:0]        MOD_BUSY,
    output reg               BUSY
);
    localparam RS_IDLE = 2'h0;
    localparam RS_WAIT = 2'h1;
    localparam RS_DONE = 2'h2;
    reg  [1:0]        rd_state;
    reg  [3:0]        ws_cnt;
    reg  [ADDR_W-1:0] last_addr;
    reg  [ADDR_W-1:0] pf_addr;
    reg               pf_valid;
    reg  [ADDR_W-1:0] cache_addr;
    reg               cache_valid;
    reg  [2:0]        ws_held;
    reg               wse_held;
    reg  [6:0]        tb_cnt;
    reg               tb_tick;
    reg  [22:0]       mod_cnt [0:4];
    reg  [1:0]        ovh_cnt [0:4];
    wire              seq_hit;
    wire              c_hit;
    wire              op_bad_mod;
    wire              op_mod_busy;
    wire              op_own_src;
    wire              op_overload;
    wire              tb_wrap;
    reg               rd_cacheable;

    integer           i;

    // Miss cost: programmed states, the extension and the cache refill.
    function [3:0] miss_waits;
        input [2:0] ws;
        input       ext;
        input       cached;
        begin
            miss_waits = {1'b0, ws} + {3'h0, ext} + {3'h0, cached};
        end
    endfunction

    function [2:0] ones5;
        input [4:0] v;
        begin
            ones5 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]}
                  + {2'h0, v[3]} + {2'h0, v[4]};
        end
    endfunction

    // Safe access forces the reset count of 4 with the extension on so a reset cannot violate timing.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            ws_held  <= `FAC_WS_RST;
            wse_held <= `FAC_WSE_RST;
        end else if (SAFE_ACCESS_AFTER_RESET) begin
            ws_held  <= `FAC_WS_RST;
            wse_held <= 1'h1;
        end else begin
            ws_held  <= WAIT_STATE_COUNT;
            wse_held <= WAIT_STATE_EXTENSION;
        end
    end

    assign seq_hit = pf_valid && (RD_ADDR == pf_addr);
    assign c_hit   = RD_CACHEABLE && cache_valid && (RD_ADDR == cache_addr);
    assign op_bad_mod  = (OP_MODULE > `FAC_FREE_MOD);
    assign op_mod_busy = !op_bad_mod && MOD_BUSY[OP_MODULE];
    // Own-source refusal holds whether reads span one module or several.
    assign op_own_src  = (OP_MODULE == RD_SRC)
                      && (OP_MODULE != `FAC_FREE_MOD);
    assign op_overload = RD_MULTI_SRC
                      && (ones5(MOD_BUSY) != 3'h0);
    assign tb_wrap     = (tb_cnt == TB_DIV - 1);

    always @(posedge CLK_SYS) begin
        if (SRST) begin
            rd_state     <= RS_IDLE;
            ws_cnt       <= 4'h0;
            last_addr    <= {ADDR_W{1'b0}};
            pf_addr      <= {ADDR_W{1'b0}};
            pf_valid     <= 1'b0;
            cache_addr   <= {ADDR_W{1'b0}};
            cache_valid  <= 1'b0;
            rd_cacheable <= 1'b0;
            RD_DONE      <= 1'b0;
            RD_SEQ_HIT   <= 1'b0;
            RD_CACHE_HIT <= 1'b0;
        end else begin
            RD_DONE <= 1'b0;
            case (rd_state)
                RS_IDLE: begin
                    if (RD_REQ) begin
                        last_addr    <= RD_ADDR;
                        rd_cacheable <= RD_CACHEABLE;
                        RD_SEQ_HIT   <= seq_hit;
                        RD_CACHE_HIT <= c_hit;
                        if (c_hit || seq_hit) begin
                            rd_state <= RS_DONE;
                        end else begin
                            // A cache miss costs one extra state unless the held wait count and extension are both zero.
                            ws_cnt <= miss_waits(ws_held, wse_held,
                                                 RD_CACHEABLE);
                            rd_state <= RS_WAIT;
                        end
                    end
                end
                RS_WAIT: begin
                    if (ws_cnt <= 4'h1) begin
                        rd_state <= RS_DONE;
                    end else begin
                        ws_cnt <= ws_cnt - 4'h1;
                    end
                end
                RS_DONE: begin
                    RD_DONE  <= 1'b1;
                    pf_addr  <= last_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                    pf_valid <= 1'b1;
                    if (RD_CACHE_HIT == 1'b0 && RD_SEQ_HIT == 1'b0) begin
                        cache_addr  <= last_addr;
                        // The captured range bit is used, the pin may move.
                        cache_valid <= rd_cacheable;
                    end
                    rd_state <= RS_IDLE;
                end
                default: rd_state <= RS_IDLE;
            endcase
        end
    end

    // Flash time base: one tick per microsecond.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            tb_cnt  <= 7'h0;
            tb_tick <= 1'b0;
        end else begin
            tb_tick <= tb_wrap;
            tb_cnt  <= tb_wrap ? 7'h0 : tb_cnt + 7'h1;
        end
    end

    // Counts are cycles; the time base only gates the decrement rate.
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            OP_ACCEPT <= 1'b0;
            OP_REJECT <= 1'b0;
            MOD_BUSY  <= 5'h0;
            BUSY      <= 1'b0;
            for (i = 0; i < `FAC_NUM_MOD; i = i + 1) begin
                mod_cnt[i] <= 23'h0;
                ovh_cnt[i] <= 2'h0;
            end
        end else begin
            OP_ACCEPT <= 1'b0;
            OP_REJECT <= 1'b0;
            for (i = 0; i < `FAC_NUM_MOD; i = i + 1) begin
                if (MOD_BUSY[i]) begin
                    if (ovh_cnt[i] != 2'h0) begin
                        ovh_cnt[i] <= ovh_cnt[i] - 2'h1;
                    end else if (mod_cnt[i] > TB_DIV[22:0]) begin
                        if (tb_tick) begin
                            mod_cnt[i] <= mod_cnt[i] - TB_DIV[22:0];
                        end
                    end else begin
                        MOD_BUSY[i] <= 1'b0;
                    end
                end
            end
            if (OP_REQ) begin
                // Own-source and overload requests are refused, not queued.
                if (op_bad_mod || op_mod_busy || op_own_src
                    || op_overload) begin
                    OP_REJECT <= 1'b1;
                end else begin
                    OP_ACCEPT           <= 1'b1;
                    MOD_BUSY[OP_MODULE] <= 1'b1;
                    ovh_cnt[OP_MODULE]  <= `FAC_SM_OVH;
                    mod_cnt[OP_MODULE]  <= (OP_KIND == `FAC_OP_PROG)
                                         ? PR_CYC[22:0] : ER_CYC[22:0];
                end
            end
            BUSY <= (MOD_BUSY != 5'h0) || OP_REQ;
        end
    end
endmodule

/* File: testbench/fac_flash_ctrl_properties.sv */
`timescale 1ns/10ps
module fac_flash_ctrl_properties #(parameter ER_CYC = 1000) (
    input wire       CLK_SYS,
    input wire       SRST,
    input wire       RD_REQ,
    input wire       RD_MULTI_SRC,
    input wire       OP_REQ,
    input wire       RD_DONE,
    input wire       RD_SEQ_HIT,
    input wire       RD_CACHE_HIT,
    input wire       OP_ACCEPT,
    input wire       OP_REJECT,
    input wire       BUSY,
    input wire [2:0] RD_SRC,
    input wire [2:0] OP_MODULE,
    input wire [4:0] MOD_BUSY
);
    localparam int T_MAX = ER_CYC + 10;
    int              dur_cnt;
    // Long busy spans are counted here instead of a huge delay range.
    always @(posedge CLK_SYS) begin
        if (SRST || !MOD_BUSY[2]) begin
            dur_cnt <= 0;
        end else begin
            dur_cnt <= dur_cnt + 1;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    sequence s_seq; RD_REQ ##1 RD_SEQ_HIT; endsequence
    sequence s_hit; RD_REQ ##1 RD_CACHE_HIT; endsequence
    property p_seq; s_seq |-> ##1 RD_DONE; endproperty
    property p_hit; s_hit |-> ##1 RD_DONE; endproperty
    property p_free; OP_REQ && OP_MODULE == 3'h4 && !BUSY |=> OP_ACCEPT;
    endproperty
    property p_other; OP_REQ && !RD_MULTI_SRC && OP_MODULE < 3'h4 &&
        OP_MODULE != RD_SRC && !MOD_BUSY[OP_MODULE] |=> OP_ACCEPT;
    endproperty
    property p_same; OP_REQ && OP_MODULE == RD_SRC && OP_MODULE != 3'h4
        |=> OP_REJECT; endproperty
    property p_rng; OP_REQ && OP_MODULE > 3'h4 |=> OP_REJECT; endproperty
    property p_acc; OP_ACCEPT |-> BUSY && MOD_BUSY != 5'h00; endproperty
    property p_dur; MOD_BUSY[2] |-> dur_cnt < T_MAX; endproperty
    a_seq: assert property (p_seq) else $error("slow prefetch");
    a_hit: assert property (p_hit) else $error("slow hit");
    a_free: assert property (p_free) else $error("free refused");
    a_other: assert property (p_other) else $error("job refused");
    a_same: assert property (p_same) else $error("own written");
    a_rng: assert property (p_rng) else $error("bad module");
    a_acc: assert property (p_acc) else $error("busy missing");
    a_dur: assert property (p_dur) else $error("erase too long");
endmodule

/* File: testbench/fac_core_model.sv */
`timescale 1ns/10ps
module fac_core_model (
    input  wire        CLK_SYS,
    input  wire        RD_DONE,
    input  wire        OP_ACCEPT,
    input  wire        OP_REJECT,
    output reg         RD_REQ = 1'b0,
    output reg         OP_REQ = 1'b0,
    output reg         RD_CACHEABLE = 1'b0,
    output reg         OP_KIND = 1'b0,
    output reg  [15:0] RD_ADDR = 16'h0000,
    output reg  [2:0]  OP_MODULE = 3'h0
);
    task rd(input [15:0] a, input c, output integer k);
        @(negedge CLK_SYS);
        {RD_REQ, RD_ADDR, RD_CACHEABLE} = {1'b1, a, c};
        @(negedge CLK_SYS);
        RD_REQ = 1'b0;
        for (k = 1; k < 40 && RD_DONE !== 1'b1; k = k + 1) @(negedge CLK_SYS);
        RD_ADDR = ~a; // An idle address toggles so no stale value passes.
    endtask
    // The read source is not driven here; the testbench sets RD_SRC and RD_MULTI_SRC, for acceptances as well as refusals.
    task op(input [2:0] m, input kd, output [1:0] r);
        @(negedge CLK_SYS);
        {OP_REQ, OP_MODULE, OP_KIND} = {1'b1, m, kd};
        @(negedge CLK_SYS);
        OP_REQ = 1'b0;
        r = {OP_ACCEPT, OP_REJECT};
    endtask
endmodule

/* File: testbench/test_fac_flash_ctrl.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) \
    begin error_cnt = error_cnt + 1; $display("mismatch %s %0h %0h", n, e, g); \
    end end
bind fac_flash_ctrl fac_flash_ctrl_properties #(.ER_CYC(ER_CYC)) u_chk (
    .CLK_SYS     (CLK_SYS),
    .SRST        (SRST),
    .RD_REQ      (RD_REQ),
    .RD_MULTI_SRC(RD_MULTI_SRC),
    .OP_REQ      (OP_REQ),
    .RD_DONE     (RD_DONE),
    .RD_SEQ_HIT  (RD_SEQ_HIT),
    .RD_CACHE_HIT(RD_CACHE_HIT),
    .OP_ACCEPT   (OP_ACCEPT),
    .OP_REJECT   (OP_REJECT),
    .BUSY        (BUSY),
    .RD_SRC      (RD_SRC),
    .OP_MODULE   (OP_MODULE),
    .MOD_BUSY    (MOD_BUSY)
);
module test_fac_flash_ctrl;
    localparam ER = 1000, PR = 500;
    reg         CLK_SYS = 1'b0, SRST = 1'b1, RD_MULTI_SRC = 1'b0;
    reg         WAIT_STATE_EXTENSION = 1'b1, SAFE_ACCESS_AFTER_RESET = 1'b1;
    reg  [2:0]  WAIT_STATE_COUNT = 3'h4, RD_SRC = 3'h0;
    wire        RD_REQ, RD_CACHEABLE, OP_REQ, OP_KIND, RD_DONE, RD_SEQ_HIT;
    wire        RD_CACHE_HIT, OP_ACCEPT, OP_REJECT, BUSY;
    wire [15:0] RD_ADDR;
    wire [2:0]  OP_MODULE;
    wire [4:0]  MOD_BUSY;
    integer     error_cnt = 0, cmp_count = 0, seed = 32'h0964EFB1, k, i, t;
    reg  [15:0] a = 16'h0000;
    reg  [3:0]  w;
    reg  [1:0]  r;
    fac_flash_ctrl #(.ER_CYC(ER), .PR_CYC(PR)) DUT (
        .CLK_SYS                (CLK_SYS),
        .SRST                   (SRST),
        .WAIT_STATE_COUNT       (WAIT_STATE_COUNT),
        .WAIT_STATE_EXTENSION   (WAIT_STATE_EXTENSION),
        .SAFE_ACCESS_AFTER_RESET(SAFE_ACCESS_AFTER_RESET),
        .RD_REQ                 (RD_REQ),
        .RD_ADDR                (RD_ADDR),
        .RD_CACHEABLE           (RD_CACHEABLE),
        .RD_SRC                 (RD_SRC),
        .RD_MULTI_SRC           (RD_MULTI_SRC),
        .OP_REQ                 (OP_REQ),
        .OP_KIND                (OP_KIND),
        .OP_MODULE              (OP_MODULE),
        .RD_DONE                (RD_DONE),
        .RD_SEQ_HIT             (RD_SEQ_HIT),
        .RD_CACHE_HIT           (RD_CACHE_HIT),
        .OP_ACCEPT              (OP_ACCEPT),
        .OP_REJECT              (OP_REJECT),
        .MOD_BUSY               (MOD_BUSY),
        .BUSY                   (BUSY)
    );
    fac_core_model core (
        .CLK_SYS     (CLK_SYS),
        .RD_DONE     (RD_DONE),
        .OP_ACCEPT   (OP_ACCEPT),
        .OP_REJECT   (OP_REJECT),
        .RD_REQ      (RD_REQ),
        .OP_REQ      (OP_REQ),
        .RD_CACHEABLE(RD_CACHEABLE),
        .OP_KIND     (OP_KIND),
        .RD_ADDR     (RD_ADDR),
        .OP_MODULE   (OP_MODULE)
    );
    function integer lat(input [2:0] ws, input e, s, c, h);
        lat = h ? 2 : 2 + (s ? 5 : ws + e) + c;
        if (!h && lat < 3) lat = 3;
    endfunction
    task rd2(input [15:0] ad, input c, h);
        t = lat(WAIT_STATE_COUNT, WAIT_STATE_EXTENSION,
            SAFE_ACCESS_AFTER_RESET, c, h);
        core.rd(ad, c, k);
        `CHK("rd cycles", t, k)
        if (k == 40) finish_test;
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #5 CLK_SYS = ~CLK_SYS;
    initial begin
        repeat (6) @(negedge CLK_SYS);
        SRST = 1'b0;
        `CHK("idle", 6'h00, {BUSY, MOD_BUSY})
        for (i = 0; i < 20; i = i + 1) begin
            w = $random(seed);
            {WAIT_STATE_COUNT, WAIT_STATE_EXTENSION} = w;
            SAFE_ACCESS_AFTER_RESET = w[1] & i[0];
            a = a + 16'h0013 + w;
            rd2(a, 1'b0, 1'b0);
            rd2(a + 16'h0001, 1'b0, 1'b1);
        end
        rd2(16'h4000, 1'b1, 1'b0);
        rd2(16'h4000, 1'b1, 1'b1);
        core.op(3'h0, 1'b0, r);
        `CHK("own src", 2'h1, r)
        for (i = 1; i < 5; i = i + 1) begin
            core.op(i[2:0], i[0], r);
            `CHK("parallel", 2'h2, r)
        end
        `CHK("busy", 5'h1E, MOD_BUSY)
        core.op(3'h5, 1'b0, r);
        `CHK("bad module", 2'h1, r)
        for (t = 0; t < 3000 && BUSY !== 1'b0; t = t + 1) @(negedge CLK_SYS);
        `CHK("erase time", 1'b1, t > PR && t < ER + 10)
        if (t == 3000) finish_test;
        {RD_SRC, RD_MULTI_SRC} = {3'h3, 1'b1};
        core.op(3'h4, 1'b0, r);
        `CHK("module 4", 2'h2, r)
        core.op(3'h1, 1'b1, r);
        `CHK("second job", 2'h1, r)
        core.op(3'h3, 1'b0, r);
        `CHK("own multi", 2'h1, r)
        SRST = 1'b1;
        repeat (2) @(negedge CLK_SYS);
        SRST = 1'b0;
        `CHK("reset", 6'h00, {BUSY, MOD_BUSY})
        finish_test;
    end
endmodule
